// file: design/wsr_defines.svh
// Constant definitions for the warm and software reset sequencer
`ifndef WSR_DEFINES_SVH
`define WSR_DEFINES_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define WSR_OFS_CTRL 8'h00
`define WSR_OFS_STATUS 8'h04
`define WSR_OFS_CONFIG 8'h08

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define WSR_CTRL_SWRST_BIT 0
`define WSR_CTRL_EOI_BIT 1
`define WSR_CTRL_BDEN_BIT 3

// ------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------
`define WSR_ST_FLAGS_LSB 0
`define WSR_ST_FLAGS_MSB 4
`define WSR_ST_EOI_BIT 8
`define WSR_ST_STATE_LSB 12
`define WSR_ST_STATE_MSB 14

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define WSR_CONFIG_RST 16'hffff
`define WSR_SW_FORCED_ONES 16'h00fc
`define WSR_SW_LATCH_MASK 16'h1f00
`define WSR_BOOT_ADDR 24'h00_0000

// ------------------------------------------------------------
// Timing in half-CPU-period units and derived cycle counts
// ------------------------------------------------------------
`define WSR_TCL_PER_CYC 2
`define WSR_MINPULSE_TCL 4
`define WSR_ABORT_TCL 12
`define WSR_SEQ_TCL 1024
`define WSR_SAMPLE_TCL 8
`define WSR_TRANSP_TCL 4
// Least times round up
`define WSR_MINPULSE_CYC ((`WSR_MINPULSE_TCL + `WSR_TCL_PER_CYC - 1) / `WSR_TCL_PER_CYC)
`define WSR_SEQ_CYC ((`WSR_SEQ_TCL + `WSR_TCL_PER_CYC - 1) / `WSR_TCL_PER_CYC)
`define WSR_SAMPLE_CYC ((`WSR_SAMPLE_TCL + `WSR_TCL_PER_CYC - 1) / `WSR_TCL_PER_CYC)
// Longest times round down
`define WSR_ABORT_CYC (`WSR_ABORT_TCL / `WSR_TCL_PER_CYC)
`define WSR_TRANSP_CYC (`WSR_TRANSP_TCL / `WSR_TCL_PER_CYC)

`endif

// file: design/wsr_pkg.sv
// Types shared by the warm and software reset sequencer
package wsr_pkg;

	// Sequencer states
	typedef enum logic [2:0] {
		WSR_RUN = 3'b000,
		WSR_ABORT = 3'b001,
		WSR_SEQ = 3'b010,
		WSR_SAMPLE = 3'b011,
		WSR_LONG = 3'b100,
		WSR_ASYNC = 3'b101,
		WSR_EXIT = 3'b110
	} wsr_state_t;

	// Sticky reset cause flags seen by software
	typedef struct packed {
		logic flash_fault;
		logic async_rst;
		logic sw_rst;
		logic long_rst;
		logic short_rst;
	} wsr_flags_t;

endpackage : wsr_pkg

// file: design/wsr_seq.sv
// Warm and software reset sequencer with AHB-Lite register slave
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "wsr_defines.svh"

module wsr_seq (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Reset pins
	input wire logic reset_input_n_in,
	output logic reset_input_n_out,
	output logic reset_input_n_oe_n,
	input wire logic powerdown_sense_pin,
	output logic sense_pulldown_en,
	output logic reset_output_n,
	// Boot and configuration pins
	input wire logic external_boot_select_n,
	input wire logic [15:0] port0_in,
	input wire logic flash_init_done,
	input wire logic int_access_busy,
	// Core side controls
	output logic io_hiz,
	output logic hold_cancel,
	output logic bus_abort,
	output logic clock_option_pins_transparent,
	output logic sense_transparent,
	output logic flash_read_ffff,
	output logic ale,
	output logic rd_n,
	output logic write_strobe_n,
	output logic cpu_start,
	output logic [23:0] fetch_addr,
	output logic [15:0] system_config
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] rst_sync; // Reset input chain, [0] feeds only [1]
	logic [2:0] rpd_sync; // Sense pin chain
	logic [15:0] p0_s1, p0_s2, p0_s3; // Port0 chain
	logic filtered_reset_input; // Qualified reset input level
	logic rpd_level; // Qualified sense level
	logic [15:0] p0_level; // Qualified port0 value

	// Three stages, the level only moves once stages two and three agree
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_sync <= 3'h7;
			rpd_sync <= 3'h7;
			filtered_reset_input <= 1'b1;
			rpd_level <= 1'b1;
		end else begin
			rst_sync <= {rst_sync[1:0], reset_input_n_in};
			rpd_sync <= {rpd_sync[1:0], powerdown_sense_pin};
			if (rst_sync[2] == rst_sync[1])
				filtered_reset_input <= rst_sync[2];
			if (rpd_sync[2] == rpd_sync[1])
				rpd_level <= rpd_sync[2];
		end
	end

	// Port0 uses the same agreement rule bit by bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			p0_s1 <= 16'hffff;
			p0_s2 <= 16'hffff;
			p0_s3 <= 16'hffff;
			p0_level <= 16'hffff;
		end else begin
			p0_s1 <= port0_in;
			p0_s2 <= p0_s1;
			p0_s3 <= p0_s2;
			p0_level <= (p0_s2 & p0_s3) | (p0_level & (p0_s2 ^ p0_s3));
		end
	end

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	wsr_pkg::wsr_state_t state; // Sequencer state
	wsr_pkg::wsr_state_t next_state;
	wsr_pkg::wsr_flags_t flags; // Sticky cause flags
	logic bidir_reset_enable; // Bidirectional reset enable
	logic eoi_done; // End of init executed since last reset
	logic sw_mode; // Current sequence came from software
	logic async_mode; // Sticky conversion to asynchronous
	logic [9:0] cnt; // Phase counter, one count per two HALF_CPU_PERIOD_UNIT
	logic [1:0] low_cnt; // Length of current reset input low pulse

	// ------------------------------------------------------------
	// AHB-Lite address phase capture
	// ------------------------------------------------------------
	logic wr_pend; // Write data phase pending
	logic [7:0] wr_addr; // Address of pending write
	wire logic req_valid = hsel && hready && htrans[1];
	wire logic word_ok = (hsize == 3'h2) && (haddr[1:0] == 2'h0);
	wire logic wr_ctrl = wr_pend && (wr_addr == `WSR_OFS_CTRL);
	wire logic wr_status = wr_pend && (wr_addr == `WSR_OFS_STATUS);
	wire logic sw_req = wr_ctrl && hwdata[`WSR_CTRL_SWRST_BIT] && (state == wsr_pkg::WSR_RUN);
	wire logic eoi_req = wr_ctrl && hwdata[`WSR_CTRL_EOI_BIT] && (state == wsr_pkg::WSR_RUN);

	// Read mux, unmapped offsets answer zero
	wire logic [31:0] status_word = {17'h0, state, 3'h0, eoi_done, 3'h0, flags};
	wire logic [31:0] ctrl_word = {28'h0, bidir_reset_enable, 3'h0};
	wire logic [31:0] rd_word =
		(haddr[7:0] == `WSR_OFS_CTRL) ? ctrl_word :
		(haddr[7:0] == `WSR_OFS_STATUS) ? status_word :
		(haddr[7:0] == `WSR_OFS_CONFIG) ? {16'h0, system_config} : 32'h0;
	wire logic in_page = (haddr[31:8] == 24'h0);

	// Zero wait state slave: read data launched at the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend <= req_valid && hwrite && word_ok && in_page;
			wr_addr <= haddr[7:0];
			if (req_valid && !hwrite)
				hrdata <= (word_ok && in_page) ? rd_word : 32'h0;
		end
	end

	// ------------------------------------------------------------
	// Reset detection
	// ------------------------------------------------------------
	// Warm trigger: reset input low for the minimum width, sense high
	wire logic pulse_ok = (low_cnt >= 2'(`WSR_MINPULSE_CYC - 1)) && !filtered_reset_input;
	wire logic hw_start = pulse_ok && rpd_level;
	// A low too short to start a reset still hits the flash; the filter
	// never shows such a pulse, so a lone low in the last stage is the mark
	wire logic short_glitch = !rst_sync[2] && rst_sync[1] && filtered_reset_input;
	wire logic in_reset = (state != wsr_pkg::WSR_RUN);
	wire logic seq_end = (state == wsr_pkg::WSR_SEQ) && (cnt == 10'(`WSR_SEQ_CYC - 1));
	// Sense pin falls during a hardware warm reset
	wire logic go_async = in_reset && !sw_mode && !rpd_level && !filtered_reset_input;
	wire logic exit_ok = filtered_reset_input && (external_boot_select_n ? flash_init_done : 1'b1);
	wire logic leaving = (state == wsr_pkg::WSR_EXIT) && exit_ok;

	// Pulse width measure on the filtered input
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_cnt <= 2'h0;
		end else begin
			if (filtered_reset_input)
				low_cnt <= 2'h0;
			else if (low_cnt != 2'h3)
				low_cnt <= low_cnt + 2'h1;
		end
	end

	// ------------------------------------------------------------
	// Sequencer next state
	// ------------------------------------------------------------
	// Counter runs in CPU cycles, each worth two HALF_CPU_PERIOD_UNIT
	always_comb begin
		next_state = state;
		case (state)
			wsr_pkg::WSR_RUN: begin
				if (hw_start || sw_req)
					next_state = wsr_pkg::WSR_ABORT;
			end
			wsr_pkg::WSR_ABORT: begin
				// Leave once the access ends, never later than the limit
				if (!int_access_busy || cnt == 10'(`WSR_ABORT_CYC - 1))
					next_state = wsr_pkg::WSR_SEQ;
			end
			wsr_pkg::WSR_SEQ: begin
				if (seq_end)
					next_state = wsr_pkg::WSR_SAMPLE;
			end
			wsr_pkg::WSR_SAMPLE: begin
				if (cnt == 10'(`WSR_SAMPLE_CYC - 1))
					next_state = filtered_reset_input ? wsr_pkg::WSR_EXIT : wsr_pkg::WSR_LONG;
			end
			wsr_pkg::WSR_LONG: begin
				// Hold transparency until input high plus the guard time
				if (filtered_reset_input && cnt == 10'(`WSR_TRANSP_CYC - 1))
					next_state = wsr_pkg::WSR_EXIT;
			end
			wsr_pkg::WSR_ASYNC: begin
				if (filtered_reset_input)
					next_state = wsr_pkg::WSR_EXIT;
			end
			wsr_pkg::WSR_EXIT: begin
				if (exit_ok)
					next_state = wsr_pkg::WSR_RUN;
			end
			default: begin
				next_state = wsr_pkg::WSR_RUN;
			end
		endcase
		// Asynchronous conversion overrides any phase except the exit
		if (go_async && state != wsr_pkg::WSR_ASYNC && state != wsr_pkg::WSR_EXIT)
			next_state = wsr_pkg::WSR_ASYNC;
	end

	// State and phase counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= wsr_pkg::WSR_RUN;
			cnt <= 10'h0;
		end else begin
			state <= next_state;
			if (next_state != state || (state == wsr_pkg::WSR_LONG && !filtered_reset_input))
				cnt <= 10'h0;
			else if (cnt != 10'h3ff)
				cnt <= cnt + 10'h1;
		end
	end

	// ------------------------------------------------------------
	// Cause flags and mode bits
	// ------------------------------------------------------------
	wire logic sample_now = (state == wsr_pkg::WSR_SAMPLE) && (cnt == 10'(`WSR_SAMPLE_CYC - 1));
	wire logic start_seq = (state == wsr_pkg::WSR_RUN) && (hw_start || sw_req);
	wire wsr_pkg::wsr_flags_t set_flags = '{
		flash_fault: short_glitch && !in_reset,
		async_rst: go_async && !async_mode,
		sw_rst: start_seq && !hw_start,
		long_rst: sample_now && !filtered_reset_input,
		short_rst: (start_seq && hw_start) || (sample_now && sw_mode && !filtered_reset_input)
	};
	wire wsr_pkg::wsr_flags_t clr_flags = wr_status ? wsr_pkg::wsr_flags_t'(hwdata[4:0]) : '0;

	// Write one clears; a new event in the same cycle wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags <= '0;
		end else begin
			flags <= (flags & ~clr_flags) | set_flags;
		end
	end

	// Mode bits: software origin and sticky asynchronous conversion
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sw_mode <= 1'b0;
			async_mode <= 1'b0;
		end else begin
			if (start_seq)
				sw_mode <= !hw_start;
			else if (sample_now && !filtered_reset_input)
				sw_mode <= 1'b0; // Input still low: becomes hardware reset
			if (go_async)
				async_mode <= 1'b1;
			else if (leaving)
				async_mode <= 1'b0;
		end
	end

	// Bidir enable: init window only, cleared by every sequence end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bidir_reset_enable <= 1'b0;
			eoi_done <= 1'b0;
		end else begin
			if (leaving)
				bidir_reset_enable <= 1'b0;
			else if (wr_ctrl && !eoi_done && !in_reset)
				bidir_reset_enable <= hwdata[`WSR_CTRL_BDEN_BIT];
			if (start_seq)
				eoi_done <= 1'b0;
			else if (eoi_req)
				eoi_done <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Pin and core outputs
	// ------------------------------------------------------------
	// Pull-down lives from detection until the sequence ends
	wire logic pd_phase = (next_state == wsr_pkg::WSR_ABORT) || (next_state == wsr_pkg::WSR_SEQ);
	// A software reset only pulls while the sense pin is high
	wire logic next_pd = bidir_reset_enable && pd_phase && !async_mode && !go_async
		&& (!sw_mode || start_seq || rpd_level) && !(start_seq && !hw_start && !rpd_level);
	wire logic next_in_reset = (next_state != wsr_pkg::WSR_RUN);

	// Reset pin drive and sense pin pull-down
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reset_input_n_out <= 1'b0;
			reset_input_n_oe_n <= 1'b1;
			sense_pulldown_en <= 1'b0;
		end else begin
			reset_input_n_out <= 1'b0;
			reset_input_n_oe_n <= !next_pd;
			sense_pulldown_en <= !filtered_reset_input || next_pd;
		end
	end

	// Reset output stays low until end of init after the exit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reset_output_n <= 1'b0;
		end else if (start_seq) begin
			reset_output_n <= 1'b0;
		end else if (eoi_req) begin
			reset_output_n <= 1'b1;
		end
	end

	// I/O floating, hold cancel and bus abort
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			io_hiz <= 1'b1;
			hold_cancel <= 1'b0;
			bus_abort <= 1'b0;
		end else begin
			io_hiz <= next_in_reset;
			hold_cancel <= (next_state == wsr_pkg::WSR_ABORT);
			bus_abort <= (next_state == wsr_pkg::WSR_ABORT);
		end
	end

	// Transparency of clock option pins and sense pin
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clock_option_pins_transparent <= 1'b0;
			sense_transparent <= 1'b0;
		end else begin
			clock_option_pins_transparent <= (next_state == wsr_pkg::WSR_LONG);
			// Only the filtered input opens the sense pin path
			sense_transparent <= !filtered_reset_input;
		end
	end

	// Flash returns all ones after a pulse too short for the core
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flash_read_ffff <= 1'b0;
		end else if (short_glitch && !in_reset) begin
			flash_read_ffff <= 1'b1;
		end else if (start_seq) begin
			flash_read_ffff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Restart: configuration latch, strobes and boot vector
	// ------------------------------------------------------------
	// Software reset keeps the old low bits and forces bits 7:2 high
	wire logic [15:0] sw_config = (p0_level & `WSR_SW_LATCH_MASK)
		| (system_config & ~`WSR_SW_LATCH_MASK) | `WSR_SW_FORCED_ONES;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			system_config <= `WSR_CONFIG_RST;
			ale <= 1'b0;
			rd_n <= 1'b1;
			write_strobe_n <= 1'b1;
			cpu_start <= 1'b0;
			fetch_addr <= `WSR_BOOT_ADDR;
		end else begin
			cpu_start <= leaving;
			if (leaving) begin
				system_config <= sw_mode ? sw_config : p0_level;
				ale <= 1'b0;
				rd_n <= 1'b1;
				write_strobe_n <= 1'b1;
				fetch_addr <= `WSR_BOOT_ADDR;
			end
		end
	end

endmodule : wsr_seq
`default_nettype wire

// file: bench/wsr_checker.sv
// Port checker for the reset sequencer, bound into the design
`timescale 1ns/1ps
`default_nettype none
module wsr_checker (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Reset pins
	input wire logic reset_input_n_in,
	input wire logic reset_input_n_oe_n,
	input wire logic sense_pulldown_en,
	input wire logic reset_output_n,
	// Core side
	input wire logic io_hiz,
	input wire logic hold_cancel,
	input wire logic clock_option_pins_transparent,
	input wire logic sense_transparent,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic write_strobe_n,
	input wire logic cpu_start,
	input wire logic [23:0] fetch_addr
);
	// Cycles since abort ended; saturates so idle time cannot wrap into a false match
	logic [9:0] seq_cnt;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// Restart in abort so each sequence is timed on its own
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seq_cnt <= 10'h000;
		end else if (hold_cancel) begin
			seq_cnt <= 10'h000;
		end else if (seq_cnt != 10'h3ff) begin
			seq_cnt <= seq_cnt + 10'h001;
		end
	end
	// ----
	// Properties
	// ----
	a_pin_starts: assert property (!reset_input_n_in [*8] |-> io_hiz && !reset_output_n)
		else $error("reset pin held low but no reset active");
	a_abort_bound: assert property ($rose(hold_cancel) |-> ##[1:6] !hold_cancel)
		else $error("abort phase longer than six cycles");
	// 512 sequence cycles plus 4 sample cycles before port0 opens
	a_seq_exact: assert property ($rose(clock_option_pins_transparent) |-> seq_cnt == 10'h204)
		else $error("long reset not 516 cycles after abort");
	a_transp_end: assert property ($fell(sense_transparent) && clock_option_pins_transparent |->
		##[1:2] !clock_option_pins_transparent)
		else $error("port0 transparency held too long");
	a_pd_sense: assert property ($fell(reset_input_n_oe_n) |-> ##[0:1] sense_pulldown_en)
		else $error("bidir pull-down without sense pull-down");
	a_pin_sense: assert property (!reset_input_n_in [*4] |-> ##[0:2] sense_pulldown_en)
		else $error("reset pin low without sense pull-down");
	a_fetch_vector: assert property (cpu_start |-> fetch_addr == 24'h00_0000)
		else $error("restart address not zero");
	a_strobe_idle: assert property (cpu_start |-> !ale && rd_n && write_strobe_n)
		else $error("bus strobes active at restart");
	// Main scenarios
	c_long: cover property ($rose(clock_option_pins_transparent));
	c_start: cover property (cpu_start);
	c_bidir: cover property ($fell(reset_input_n_oe_n));
endmodule : wsr_checker

bind wsr_seq wsr_checker chk (
	.hclk(hclk), .hresetn(hresetn), .reset_input_n_in(reset_input_n_in),
	.reset_input_n_oe_n(reset_input_n_oe_n), .sense_pulldown_en(sense_pulldown_en),
	.reset_output_n(reset_output_n), .io_hiz(io_hiz), .hold_cancel(hold_cancel),
	.clock_option_pins_transparent(clock_option_pins_transparent), .sense_transparent(sense_transparent),
	.ale(ale), .rd_n(rd_n), .write_strobe_n(write_strobe_n), .cpu_start(cpu_start), .fetch_addr(fetch_addr)
);
`default_nettype wire

// file: bench/wsr_board.sv
// Board model: reset button with pull-up, RC network on the sense pin
`timescale 1ns/1ps
`default_nettype none
module wsr_board (
	// Clock
	input wire logic hclk,
	// Commands from the bench
	input wire logic button_low,
	input wire logic [1:0] rc_mode,
	// Device side
	input wire logic reset_input_n_oe_n,
	input wire logic sense_pulldown_en,
	output logic reset_pin,
	output logic sense_pin
);
	// Charge on the small sense capacitor, full at 8'h40
	logic [7:0] charge;
	// Pull-up on the pin; button or device open drain wins
	assign reset_pin = !(button_low || !reset_input_n_oe_n);
	// Mode 1 huge cap stays high, mode 2 shorted low, mode 0 small cap drains
	assign sense_pin = (rc_mode == 2'h1) || (rc_mode == 2'h0 && charge > 8'h20);
	initial charge = 8'h40;
	// Weak device pull-down drains the cap; the board resistor refills it
	always @(posedge hclk) begin
		if (sense_pulldown_en && charge != 8'h00) begin
			charge <= charge - 8'h01;
		end else if (!sense_pulldown_en && charge != 8'h40) begin
			charge <= charge + 8'h01;
		end
	end
endmodule : wsr_board
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the warm and software reset sequencer
`timescale 1ns/1ps
`default_nettype none
`include "wsr_defines.svh"
module tb;
	// Bus, pin and board signals
	logic hclk, hresetn, hsel, hwrite, hready, button_low, flash_init_done, int_access_busy, ext_boot_n;
	logic [1:0] htrans, rc_mode;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [15:0] port0_in, config_q;
	logic pin, sense, oe_n, pd_en, rst_out_n, io_hiz, transp, flash_ffff, cpu_start;
	int err_total, compares, cycles;
	// Bus hready is the one slave's hreadyout
	wsr_seq dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(), .hrdata(hrdata),
		.reset_input_n_in(pin), .reset_input_n_out(), .reset_input_n_oe_n(oe_n),
		.powerdown_sense_pin(sense), .sense_pulldown_en(pd_en), .reset_output_n(rst_out_n),
		.external_boot_select_n(ext_boot_n), .port0_in(port0_in), .flash_init_done(flash_init_done),
		.int_access_busy(int_access_busy), .io_hiz(io_hiz), .hold_cancel(), .bus_abort(),
		.clock_option_pins_transparent(transp), .sense_transparent(), .flash_read_ffff(flash_ffff),
		.ale(), .rd_n(), .write_strobe_n(), .cpu_start(cpu_start), .fetch_addr(), .system_config(config_q)
	);
	wsr_board board (
		.hclk(hclk), .button_low(button_low), .rc_mode(rc_mode), .reset_input_n_oe_n(oe_n),
		.sense_pulldown_en(pd_en), .reset_pin(pin), .sense_pin(sense)
	);
	// ----
	// Clock, hang guard and tasks
	// ----
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	// A stuck wait ends the run as a mismatch
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 10000) begin
			err_total++;
			close_out();
		end
	end
	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One single transfer; entered just after a rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h00_0000, a};
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q & m, e);
	endtask : rd
	// Wait past the restart pulse; the hang guard bounds it
	task automatic wait_go;
		while (cpu_start !== 1'b1) @(posedge hclk);
		@(posedge hclk);
	endtask : wait_go
	// ----
	// Main sequence
	// ----
	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		hsize = 3'h2;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		button_low = 1'b0;
		rc_mode = 2'h1;
		ext_boot_n = 1'b1;
		flash_init_done = 1'b1;
		int_access_busy = 1'b0;
		port0_in = 16'hffff;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		// Power-on: bidir enable clear; an unmapped write changes nothing
		wr(8'h0c, 32'h0000_0008);
		rd(`WSR_OFS_CTRL, 32'h0000_0008, 32'h0000_0000);
		rd(8'h0c, 32'hffff_ffff, 32'h0000_0000);
		// Software reset with bidir pull-down, internal boot held by flash;
		// the filter delay keeps the input low at the sample: degenerates to hardware long
		port0_in <= 16'hea01;
		flash_init_done <= 1'b0;
		wr(`WSR_OFS_CTRL, 32'h0000_0008);
		rd(`WSR_OFS_CTRL, 32'h0000_0008, 32'h0000_0008);
		wr(`WSR_OFS_CTRL, 32'h0000_0009);
		repeat (3) @(posedge hclk);
		chk({oe_n, rst_out_n, io_hiz}, 32'h0000_0001);
		repeat (600) @(posedge hclk);
		chk({oe_n, io_hiz}, 32'h0000_0003);
		flash_init_done <= 1'b1;
		wait_go();
		chk(config_q, 32'h0000_ea01);
		rd(`WSR_OFS_CTRL, 32'h0000_0008, 32'h0000_0000);
		rd(`WSR_OFS_STATUS, 32'h0000_001e, 32'h0000_0006);
		wr(`WSR_OFS_STATUS, 32'h0000_001f);
		// Software reset with sense shorted low: no pull-down, still completes
		rc_mode <= 2'h2;
		port0_in <= 16'h1500;
		repeat (6) @(posedge hclk);
		wr(`WSR_OFS_CTRL, 32'h0000_0008);
		wr(`WSR_OFS_CTRL, 32'h0000_0009);
		repeat (20) @(posedge hclk);
		chk({oe_n, io_hiz}, 32'h0000_0003);
		wait_go();
		chk(config_q, 32'h0000_f5fd);
		rc_mode <= 2'h1;
		rd(`WSR_OFS_STATUS, 32'h0000_001e, 32'h0000_0004);
		wr(`WSR_OFS_STATUS, 32'h0000_001f);
		// End of init locks the bidir enable out
		wr(`WSR_OFS_CTRL, 32'h0000_0002);
		wr(`WSR_OFS_CTRL, 32'h0000_0008);
		rd(`WSR_OFS_CTRL, 32'h0000_0008, 32'h0000_0000);
		chk(rst_out_n, 32'h0000_0001);
		// Long hardware reset, external boot, slow internal access
		ext_boot_n <= 1'b0;
		int_access_busy <= 1'b1;
		port0_in <= 16'h6c3c;
		button_low <= 1'b1;
		repeat (10) @(posedge hclk);
		chk({rst_out_n, io_hiz}, 32'h0000_0001);
		repeat (540) @(posedge hclk);
		chk({transp, io_hiz}, 32'h0000_0003);
		button_low <= 1'b0;
		int_access_busy <= 1'b0;
		wait_go();
		chk(config_q, 32'h0000_6c3c);
		rd(`WSR_OFS_STATUS, 32'h0000_001f, 32'h0000_0003);
		wr(`WSR_OFS_STATUS, 32'h0000_001f);
		// Short hardware reset at a pulse just above the minimum
		button_low <= 1'b1;
		repeat (3) @(posedge hclk);
		button_low <= 1'b0;
		wait_go();
		rd(`WSR_OFS_STATUS, 32'h0000_001f, 32'h0000_0001);
		wr(`WSR_OFS_STATUS, 32'h0000_001f);
		// Too short a pulse upsets the flash only
		button_low <= 1'b1;
		@(posedge hclk);
		button_low <= 1'b0;
		repeat (10) @(posedge hclk);
		chk({flash_ffff, io_hiz}, 32'h0000_0002);
		rd(`WSR_OFS_STATUS, 32'h0000_0010, 32'h0000_0010);
		wr(`WSR_OFS_STATUS, 32'h0000_001f);
		// Sense drains mid reset, then recovers: stays asynchronous
		rc_mode <= 2'h0;
		button_low <= 1'b1;
		repeat (100) @(posedge hclk);
		rc_mode <= 2'h1;
		repeat (500) @(posedge hclk);
		chk(transp, 32'h0000_0000);
		button_low <= 1'b0;
		wait_go();
		rd(`WSR_OFS_STATUS, 32'h0000_000a, 32'h0000_0008);
		close_out();
	end
endmodule : tb
`default_nettype wire
